// [flash_host.sv]
// Contract
// - the host holds reset high at least 50 ns before starting a read.
// - the host may start its next cycle as soon as ready/busy returns to ready.
// - each status read toggles the bits and the host may strobe it with chip or output enable.
// - the host raises the unprotect voltage at least 4 us before a write, with a 500 ns edge.
// - the host issues program as four write cycles, the last carrying address and data.
//
// Purpose: APB-controlled host that drives an asynchronous parallel flash
// Assumes: flash pins sampled through two flip-flops; 25 MHz clk_sys
// Notes:   data bus is a two-way pin: out, in, active-low output enable
`timescale 1ns/100ps
`include "flash_host_defs.svh"

module flash_host #(
   parameter int unsigned READY_ALG_CYC  = (`T_READY_ALG_US * 1000) / `CLK_PERIOD_NS,
   parameter int unsigned UNPROT_CYC     = `CYC_UP(`T_UNPROT_SETUP_US * 1000
                                                   + `T_UNPROT_EDGE_NS),
   parameter int unsigned BUSY_WAIT_CYC  = 8
) (
   input  wire logic                      clk_sys,
   input  wire logic                      reset,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   output logic                           irq,
   output flash_host_pkg::flash_ctl_t     flash_ctl,
   output logic      [15:0]               flash_dq_out,
   output logic                           flash_dq_oe_n,
   input  wire logic [15:0]               flash_dq_in,
   input  wire logic                      ready_busy_n
);
   import flash_host_pkg::*;

   // read waits access time plus the two synchroniser stages
   localparam int unsigned RD_CYC   = `CYC_UP(`T_READ_ACC_NS) + 2;
   // one extra count for the cycle in which write enable is launched
   localparam int unsigned WP_CYC   = `CYC_UP(`T_WRITE_PULSE_NS) + 1;
   localparam int unsigned WH_CYC   = `CYC_UP(`T_WRITE_HIGH_NS);
   localparam int unsigned RP_CYC   = `CYC_UP(`T_RESET_PULSE_NS);
   localparam int unsigned RH_CYC   = `CYC_UP(`T_RESET_HIGH_NS);
   localparam int unsigned TOUT_CYC = `TIMEOUT_CYC;

   // ******************************************************
   // pin synchronisers
   // ******************************************************
   logic [15:0] dq_s1_q, dq_s2_q;
   logic        rb_s1_q, rb_s2_q;
   always_ff @(posedge clk_sys) begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n;
      rb_s2_q <= rb_s1_q;
   end

   // ******************************************************
   // sequencer
   // ******************************************************
   host_state_t st_q, st_d;
   flash_ctl_t  ctl_q, ctl_d;
   logic [15:0] dout_q, dout_d, rdata_q, rdata_d, wdata_q, prev_q, prev_d;
   logic        doe_n_q, doe_n_d;
   logic [19:0] addr_q;
   logic [31:0] cnt_q, cnt_d;
   logic [2:0]  step_q, step_d;
   logic [2:0]  cmd_q, cmd_d;
   logic [9:0]  ctrl_q;
   logic        busy_q, busy_d, start;
   logic [2:0]  ev_d;
   logic [2:0]  irq_stat_q, irq_stat_d, irq_mask_q;
   logic        first_q, first_d, alg_q, alg_d;

   // four-cycle program, six-cycle erase
   function automatic logic [35:0] seq_word(input logic [2:0] c, input logic [2:0] s,
                                           input logic [19:0] a, input logic [15:0] d);
      logic [35:0] r;
      r = {`UNLOCK_ADDR1, `UNLOCK_DATA1};
      unique case (s)
         3'h1:    r = {`UNLOCK_ADDR2, `UNLOCK_DATA2};
         3'h2:    r = {`UNLOCK_ADDR1, (c == `CMD_ERASE) ? `ERASE_CODE1 : `PROG_CODE};
         3'h3:    r = (c == `CMD_ERASE) ? {`UNLOCK_ADDR1, `UNLOCK_DATA1} : {a, d};
         3'h4:    r = {`UNLOCK_ADDR2, `UNLOCK_DATA2};
         3'h5:    r = {a, `ERASE_CODE2};
         default: r = {`UNLOCK_ADDR1, `UNLOCK_DATA1};
      endcase
      return r;
   endfunction : seq_word

   wire  [2:0]  last_step = (cmd_q == `CMD_ERASE) ? 3'h5 : 3'h3;
   wire         multi     = (cmd_q == `CMD_PROGRAM) || (cmd_q == `CMD_ERASE);
   wire  [35:0] sw        = seq_word(cmd_q, step_q, addr_q, wdata_q);
   wire  [15:0] poll_diff = dq_s2_q ^ prev_q;
   wire  [15:0] susp_mask = 16'h1 << `SUSP_TOGGLE_POS;

   always_comb begin
      st_d    = st_q;
      ctl_d   = ctl_q;
      dout_d  = dout_q;
      doe_n_d = doe_n_q;
      rdata_d = rdata_q;
      prev_d  = prev_q;
      cnt_d   = (cnt_q == 32'h0) ? 32'h0 : cnt_q - 32'h1;
      step_d  = step_q;
      cmd_d   = cmd_q;
      busy_d  = busy_q;
      first_d = first_q;
      alg_d   = alg_q;
      ev_d    = 3'h0;
      unique case (st_q)
         ST_IDLE: begin
            if (start) begin
               cmd_d  = pwdata[2:0];
               busy_d = 1'b1;
               step_d = 3'h0;
               ctl_d.addr = addr_q;
               unique case (pwdata[2:0])
                  `CMD_READ: begin
                     ctl_d.chip_en_n = 1'b0;
                     ctl_d.out_en_n  = 1'b0;
                     cnt_d = 32'(RD_CYC);
                     st_d  = ST_RD;
                  end
                  `CMD_RESET: begin
                     ctl_d.reset_n = 1'b0;
                     // a busy flash means an algorithm is running
                     alg_d = alg_q || !rb_s2_q;
                     cnt_d = 32'(RP_CYC);
                     st_d  = ST_RST_LO;
                  end
                  `CMD_POLL: begin
                     first_d = 1'b1;
                     st_d    = ST_POLL_H;
                     cnt_d   = 32'(TOUT_CYC);
                  end
                  default: begin
                     if (pwdata[`CTRL_UNPROT_BIT] && !ctl_q.unprotect_high_voltage) begin
                        ctl_d.unprotect_high_voltage = 1'b1;
                        cnt_d = 32'(UNPROT_CYC);
                        st_d  = ST_UNPROT;
                     end else begin
                        st_d  = ST_WR_LO;
                        cnt_d = 32'(WP_CYC);
                     end
                  end
               endcase
            end
         end
         ST_UNPROT: if (cnt_q == 32'h1) begin
            st_d  = ST_WR_LO;
            cnt_d = 32'(WP_CYC);
         end
         ST_RD: if (cnt_q == 32'h1) begin
            rdata_d = dq_s2_q;
            ctl_d.chip_en_n = 1'b1;
            ctl_d.out_en_n  = 1'b1;
            busy_d = 1'b0;
            ev_d[`IRQ_DONE_BIT] = 1'b1;
            st_d = ST_IDLE;
         end
         ST_WR_LO: begin
            ctl_d.addr       = multi ? sw[35:16] : addr_q;
            dout_d           = multi ? sw[15:0] : wdata_q;
            doe_n_d          = 1'b0;
            ctl_d.chip_en_n  = 1'b0;
            ctl_d.write_en_n = 1'b0;
            if (cnt_q == 32'h1) begin
               ctl_d.write_en_n = 1'b1;
               ctl_d.chip_en_n  = 1'b1;
               cnt_d = 32'(WH_CYC);
               st_d  = ST_WR_HI;
            end
         end
         ST_WR_HI: if (cnt_q == 32'h1) begin
            doe_n_d = 1'b1;
            if (multi && step_q != last_step) begin
               step_d = step_q + 3'h1;
               cnt_d  = 32'(WP_CYC);
               st_d   = ST_WR_LO;
            end else if (multi) begin
               // allow time for busy to assert
               cnt_d = 32'(BUSY_WAIT_CYC);
               st_d  = ST_BUSYW;
            end else begin
               busy_d = 1'b0;
               ev_d[`IRQ_DONE_BIT] = 1'b1;
               st_d = ST_IDLE;
            end
         end
         ST_BUSYW: if (cnt_q == 32'h1) begin
            cnt_d = 32'(TOUT_CYC);
            st_d  = ST_WAITRB;
         end
         // hold off until ready again; finish with no extra gap
         ST_WAITRB: begin
            if (rb_s2_q) begin
               ctl_d.unprotect_high_voltage = 1'b0;
               busy_d = 1'b0;
               ev_d[`IRQ_DONE_BIT] = 1'b1;
               st_d = ST_IDLE;
            end else if (cnt_q == 32'h1) begin
               busy_d = 1'b0;
               ev_d[`IRQ_TIMEOUT_BIT] = 1'b1;
               st_d = ST_IDLE;
            end
         end
         ST_RST_LO: if (cnt_q == 32'h1) begin
            ctl_d.reset_n = 1'b1;
            cnt_d = alg_q ? READY_ALG_CYC : 32'(`CYC_UP(`T_READY_IDLE_NS));
            st_d  = ST_RST_HI;
         end
         ST_RST_HI: if (cnt_q <= 32'(RH_CYC) && cnt_q <= 32'h1) begin
            alg_d  = 1'b0;
            busy_d = 1'b0;
            ev_d[`IRQ_DONE_BIT] = 1'b1;
            st_d = ST_IDLE;
         end
         ST_POLL_H: begin
            ctl_d.chip_en_n = 1'b0;
            ctl_d.out_en_n  = 1'b0;
            ctl_d.addr     = addr_q;
            step_d = 3'(RD_CYC);
            st_d   = ST_POLL;
         end
         ST_POLL: begin
            step_d = step_q - 3'h1;
            if (step_q == 3'h1) begin
               if (ctrl_q[`CTRL_POLL_CE_BIT]) ctl_d.chip_en_n = 1'b1;
               else ctl_d.out_en_n = 1'b1;
               prev_d  = dq_s2_q;
               rdata_d = dq_s2_q;
               first_d = 1'b0;
               // algorithm toggle at any address; settled when only suspend bit moves
               if (!first_q && (poll_diff & ~susp_mask) == 16'h0) begin
                  // suspend toggle marks a suspended sector
                  ev_d[`IRQ_SUSP_BIT] = poll_diff[`SUSP_TOGGLE_POS];
                  ctl_d.chip_en_n = 1'b1;
                  ctl_d.out_en_n  = 1'b1;
                  busy_d = 1'b0;
                  ev_d[`IRQ_DONE_BIT] = 1'b1;
                  st_d = ST_IDLE;
               end else if (cnt_q == 32'h1) begin
                  busy_d = 1'b0;
                  ev_d[`IRQ_TIMEOUT_BIT] = 1'b1;
                  st_d = ST_IDLE;
               end else begin
                  st_d = ST_POLL_H;
               end
            end
         end
         default: st_d = ST_IDLE;
      endcase
      // a program or erase that starts marks an algorithm in flight
      if (st_q == ST_BUSYW) alg_d = 1'b1;
      if (st_q == ST_WAITRB && st_d == ST_IDLE) alg_d = !rb_s2_q;
   end

   // ******************************************************
   // apb slave and registers
   // ******************************************************
   wire wr_en = psel && penable && pwrite;
   assign start = wr_en && (paddr == `REG_CTRL) && !busy_q && (pwdata[2:0] != 3'h0);

   always_comb begin
      irq_stat_d = irq_stat_q | ev_d;
      if (wr_en && paddr == `REG_IRQ_STAT) irq_stat_d = (irq_stat_q & ~pwdata[2:0]) | ev_d;
   end

   logic [31:0] prdata_d;
   always_comb begin
      unique case (paddr)
         `REG_CTRL:     prdata_d = {22'h0, ctrl_q};
         `REG_ADDR:     prdata_d = {12'h0, addr_q};
         `REG_WDATA:    prdata_d = {16'h0, wdata_q};
         `REG_RDATA:    prdata_d = {16'h0, rdata_q};
         `REG_STATUS:   prdata_d = {27'h0, alg_q, rb_s2_q, st_q == ST_IDLE, busy_q, 1'b0};
         `REG_IRQ_STAT: prdata_d = {29'h0, irq_stat_q};
         `REG_IRQ_MASK: prdata_d = {29'h0, irq_mask_q};
         default:       prdata_d = 32'h0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q       <= ST_IDLE;
         ctl_q      <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 20'h0};
         dout_q     <= 16'h0;
         doe_n_q    <= 1'b1;
         rdata_q    <= 16'h0;
         prev_q     <= 16'h0;
         cnt_q      <= 32'h0;
         step_q     <= 3'h0;
         cmd_q      <= 3'h0;
         busy_q     <= 1'b0;
         first_q    <= 1'b0;
         alg_q      <= 1'b0;
         irq_stat_q <= 3'h0;
         irq_mask_q <= 3'h0;
         ctrl_q     <= 10'h0;
         addr_q     <= 20'h0;
         wdata_q    <= 16'h0;
         prdata     <= 32'h0;
         pready     <= 1'b0;
         irq        <= 1'b0;
      end else begin
         st_q       <= st_d;
         ctl_q      <= ctl_d;
         dout_q     <= dout_d;
         doe_n_q    <= doe_n_d;
         rdata_q    <= rdata_d;
         prev_q     <= prev_d;
         cnt_q      <= cnt_d;
         step_q     <= step_d;
         cmd_q      <= cmd_d;
         busy_q     <= busy_d;
         first_q    <= first_d;
         alg_q      <= alg_d;
         irq_stat_q <= irq_stat_d;
         if (wr_en && paddr == `REG_IRQ_MASK) irq_mask_q <= pwdata[2:0];
         if (start) ctrl_q <= pwdata[9:0];
         if (wr_en && paddr == `REG_ADDR && !busy_q) addr_q <= pwdata[19:0];
         if (wr_en && paddr == `REG_WDATA && !busy_q) wdata_q <= pwdata[15:0];
         prdata     <= prdata_d;
         pready     <= psel && !penable;
         irq        <= |(irq_stat_d & irq_mask_q);
      end
   end

   assign flash_ctl     = ctl_q;
   assign flash_dq_out  = dout_q;
   assign flash_dq_oe_n = doe_n_q;
   assign pslverr       = 1'b0;

   // ******************************************************
   // assertions
   // ******************************************************
   sequence s_reset_low;
      !ctl_q.reset_n;
   endsequence
   sequence s_we_low;
      !ctl_q.write_en_n;
   endsequence
   sequence s_strobe_off;
      ctl_q.chip_en_n || ctl_q.out_en_n;
   endsequence
   a_reset_high_read: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(ctl_q.reset_n) |-> ctl_q.out_en_n [*2])
      else $error("read too soon after reset release");
   a_no_cmd_busy: assert property (@(posedge clk_sys) disable iff (reset)
      (st_q == ST_WAITRB && !rb_s2_q) |=> (st_q != ST_WR_LO))
      else $error("write issued while flash busy");
   a_unprot_lead: assert property (@(posedge clk_sys) disable iff (reset)
      $rose(ctl_q.unprotect_high_voltage) |-> ctl_q.write_en_n [*8])
      else $error("write too soon after unprotect voltage");
   a_reset_pulse_len: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(ctl_q.reset_n) |-> s_reset_low [*8]) else $error("flash reset pulse too short");
   a_write_pulse_len: assert property (@(posedge clk_sys) disable iff (reset)
      $fell(ctl_q.write_en_n) |-> s_we_low [*2]) else $error("write pulse too short");
   a_poll_strobe_end: assert property (@(posedge clk_sys) disable iff (reset)
      (st_q == ST_POLL && step_q == 3'h1) |=> s_strobe_off) else $error("poll strobe held");
   a_ready_finish: assert property (@(posedge clk_sys) disable iff (reset)
      (st_q == ST_WAITRB && rb_s2_q) |=> (st_q == ST_IDLE && !busy_q))
      else $error("command not finished when flash ready");
endmodule : flash_host

// [flash_host_defs.svh]
// Purpose: constants for the parallel flash host controller
// Assumes: clk_sys at 25 MHz (40 ns period)
// Notes:   times in their own unit, cycle counts derived from them
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH

`define CLK_PERIOD_NS     40
// reset pulse width, least
`define T_RESET_PULSE_NS  500
// reset high before read, least
`define T_RESET_HIGH_NS   50
// reset low to ready, during an embedded algorithm, longest
`define T_READY_ALG_US    20
// reset low to ready, idle, longest
`define T_READY_IDLE_NS   500
// busy output valid after last write, longest (slowest grade)
`define T_BUSY_NS         35
// unprotect voltage setup before write, least
`define T_UNPROT_SETUP_US 4
// unprotect voltage edge time, least
`define T_UNPROT_EDGE_NS  500
// write pulse width and write pulse high (slowest grade), least
`define T_WRITE_PULSE_NS  45
`define T_WRITE_HIGH_NS   20
// read access time, slowest grade
`define T_READ_ACC_NS     90
// longest wait for a poll or for ready/busy, in cycles
`define TIMEOUT_CYC       (1 << 26)

`define CYC_UP(ns)   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_DN(ns)   (((ns) / `CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `CLK_PERIOD_NS))

// register offsets (byte addresses)
`define REG_CTRL     12'h000
`define REG_ADDR     12'h004
`define REG_WDATA    12'h008
`define REG_RDATA    12'h00C
`define REG_STATUS   12'h010
`define REG_IRQ_STAT 12'h014
`define REG_IRQ_MASK 12'h018

// control register command codes, bits [2:0]
`define CMD_READ     3'h1
`define CMD_WRITE    3'h2
`define CMD_RESET    3'h3
`define CMD_POLL     3'h4
`define CMD_PROGRAM  3'h5
`define CMD_ERASE    3'h6
// control bit 8: use chip enable (1) or output enable (0) as poll strobe
`define CTRL_POLL_CE_BIT 8
// control bit 9: raise unprotect high voltage before writes
`define CTRL_UNPROT_BIT  9

// irq status bits
`define IRQ_DONE_BIT    0
`define IRQ_TIMEOUT_BIT 1
`define IRQ_SUSP_BIT    2

// command unlock sequence
`define UNLOCK_ADDR1  20'h00555
`define UNLOCK_ADDR2  20'h002AA
`define UNLOCK_DATA1  16'h00AA
`define UNLOCK_DATA2  16'h0055
`define PROG_CODE     16'h00A0
`define ERASE_CODE1   16'h0080
`define ERASE_CODE2   16'h0030

// toggle bit positions on the data bus
`define ALG_TOGGLE_POS  6
`define SUSP_TOGGLE_POS 2
`endif

// [flash_host_pkg.sv]
// Purpose: types for the parallel flash host controller
// Assumes: nothing beyond the defs header
// Notes:   pin group travels as one struct
package flash_host_pkg;
   typedef struct packed {
      logic        chip_en_n;
      logic        out_en_n;
      logic        write_en_n;
      logic        reset_n;
      logic        unprotect_high_voltage;
      logic [19:0] addr;
   } flash_ctl_t;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_RD     = 4'b0001,
      ST_WR_LO  = 4'b0010,
      ST_WR_HI  = 4'b0011,
      ST_RST_LO = 4'b0100,
      ST_RST_HI = 4'b0101,
      ST_POLL   = 4'b0110,
      ST_POLL_H = 4'b0111,
      ST_UNPROT = 4'b1000,
      ST_BUSYW  = 4'b1001,
      ST_WAITRB = 4'b1010
   } host_state_t;
endpackage : flash_host_pkg

// [flash_dev_model.sv]
// Purpose: behavioural parallel flash on the far side of the host controller
// Assumes: host pins change on the clk_sys rising edge and are sampled here on the falling edge
// Notes:   host timing faults are counted in host_err; a released data bus shows no stale value
`timescale 1ns/100ps
`include "flash_host_defs.svh"

module flash_dev_model #(
   parameter int PROG_CYC  = 300,
   parameter int ERASE_CYC = 1000
) (
   input  wire logic                       clk_sys,
   input  wire flash_host_pkg::flash_ctl_t flash_ctl,
   input  wire logic [15:0]                flash_dq_out,
   input  wire logic                       flash_dq_oe_n,
   output logic      [15:0]                flash_dq_in,
   output logic                            ready_busy_n
);
   import flash_host_pkg::*;
   logic [15:0] mem [0:255];
   logic [15:0] cap_d, last_q;
   logic [19:0] cap_a;
   logic [3:0]  step, er_sec;
   logic        wr, rd, wr_p, rd_p, rst_p, tog, er_q;
   int          busy_cnt, lo_cnt, hi_cnt, vid_cnt, host_err, n_tog;

   // ********************
   // pins
   // ********************
   assign wr = ~flash_ctl.chip_en_n & ~flash_ctl.write_en_n;
   assign rd = ~flash_ctl.chip_en_n & ~flash_ctl.out_en_n;
   assign flash_dq_in = rd ? ((busy_cnt != 0) ? (16'(tog) << `ALG_TOGGLE_POS)
                                              : mem[flash_ctl.addr[7:0]])
                           : (!flash_dq_oe_n ? flash_dq_out : ~last_q);
   assign ready_busy_n = (busy_cnt == 0);

   initial begin
      for (int j = 0; j < 256; j++) mem[j] = 16'hFFFF;
      {step, er_sec, wr_p, rd_p, tog, er_q, cap_a, cap_d, last_q} = '0;
      rst_p = 1'b1;
      {busy_cnt, lo_cnt, vid_cnt, host_err, n_tog} = '0;
      hi_cnt = 100;
   end

   // ********************
   // sequencing
   // ********************
   always @(negedge clk_sys) begin
      wr_p    <= wr;
      rd_p    <= rd;
      rst_p   <= flash_ctl.reset_n;
      last_q  <= flash_dq_in;
      lo_cnt  <= flash_ctl.reset_n ? 0 : lo_cnt + 1;
      hi_cnt  <= flash_ctl.reset_n ? hi_cnt + 1 : 0;
      vid_cnt <= flash_ctl.unprotect_high_voltage ? vid_cnt + 1 : 0;
      if (wr) begin
         cap_a <= flash_ctl.addr;
         cap_d <= flash_dq_out;
      end
      if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1 && er_q) begin
         for (int j = 0; j < 256; j++) if (j[7:4] == er_sec) mem[j] <= 16'hFFFF;
      end
      if (rd_p && !rd && busy_cnt != 0) begin
         tog   <= ~tog;
         n_tog <= n_tog + 1;
      end
      if ((flash_ctl.reset_n && !rst_p && lo_cnt * `CLK_PERIOD_NS < 500)
          || (rd && !rd_p && hi_cnt * `CLK_PERIOD_NS < 50)
          || (wr && !wr_p && (busy_cnt != 0 || (flash_ctl.unprotect_high_voltage
              && vid_cnt * `CLK_PERIOD_NS < 4000 + 500))))
         host_err <= host_err + 1;
      if (wr_p && !wr) begin
         step <= 4'h0;
         case (step)
            4'h0, 4'h4: if (cap_a == `UNLOCK_ADDR1 && cap_d == `UNLOCK_DATA1) step <= step + 4'h1;
            4'h1, 4'h5: if (cap_a == `UNLOCK_ADDR2 && cap_d == `UNLOCK_DATA2) step <= step + 4'h1;
            4'h2: if (cap_a == `UNLOCK_ADDR1)
               step <= (cap_d == `PROG_CODE) ? 4'h3 : (cap_d == `ERASE_CODE1) ? 4'h4 : 4'h0;
            4'h3: begin
               mem[cap_a[7:0]] <= cap_d;
               busy_cnt        <= PROG_CYC;
               er_q            <= 1'b0;
            end
            4'h6: if (cap_d == `ERASE_CODE2) begin
               for (int j = 0; j < 256; j++) if (j[7:4] == cap_a[7:4]) mem[j] <= 16'h0000;
               er_sec   <= cap_a[7:4];
               busy_cnt <= ERASE_CYC;
               er_q     <= 1'b1;
            end
            default: ;
         endcase
      end
      if (!flash_ctl.reset_n) begin
         busy_cnt <= 0;
         step     <= 4'h0;
         er_q     <= 1'b0;
      end
   end
endmodule : flash_dev_model

// [testbench.sv]
// Purpose: self-checking bench for the APB flash host controller
// Assumes: flash_dev_model on the far side; no random stimulus
// Notes:   host timing faults are counted inside the model
`timescale 1ns/100ps
`include "flash_host_defs.svh"

module testbench;
   import flash_host_pkg::*;
   logic        clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq;
   logic        flash_dq_oe_n, ready_busy_n;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] flash_dq_out, flash_dq_in;
   flash_ctl_t  flash_ctl;
   int          err_count, n_tests, tg;
   logic [35:0] seq [0:9];

   flash_host dut_u (
      .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq), .flash_ctl(flash_ctl), .flash_dq_out(flash_dq_out),
      .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));
   flash_dev_model #(.PROG_CYC(300), .ERASE_CYC(1000)) flash_u (
      .clk_sys(clk_sys), .flash_ctl(flash_ctl), .flash_dq_out(flash_dq_out),
      .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in), .ready_busy_n(ready_busy_n));

   initial begin
      clk_sys = 1'b0;
      forever #(`CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   end

   // ********************
   // access tasks
   // ********************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rdat    = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, '0);
      check(rdat, exp);
      check({31'h0, pslverr}, 32'h0);
   endtask : rd_chk

   task automatic run_cmd(input logic [31:0] ctl, input logic [19:0] a, input logic [15:0] d,
                          input logic irq_exp);
      apb(1'b1, `REG_ADDR, {12'h000, a});
      apb(1'b1, `REG_WDATA, {16'h0000, d});
      apb(1'b1, `REG_CTRL, ctl);
      rdat = '0;
      for (int k = 0; k < 5000 && rdat[`IRQ_DONE_BIT] !== 1'b1; k++) apb(1'b0, `REG_IRQ_STAT, '0);
      check({31'h0, rdat[`IRQ_DONE_BIT]}, 32'h1);
      check({31'h0, irq}, {31'h0, irq_exp});
      apb(1'b1, `REG_IRQ_STAT, 32'h0000_0001);
      rd_chk(`REG_IRQ_STAT, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask : run_cmd

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // ********************
   // tests
   // ********************
   initial begin
      {reset, psel, penable, pwrite} = 4'b1000;
      paddr = '0;
      pwdata = '0;
      err_count = 0;
      n_tests = 0;
      seq = '{{`UNLOCK_ADDR1, `UNLOCK_DATA1}, {`UNLOCK_ADDR2, `UNLOCK_DATA2},
              {`UNLOCK_ADDR1, `PROG_CODE}, {20'h00023, 16'h1234},
              {`UNLOCK_ADDR1, `UNLOCK_DATA1}, {`UNLOCK_ADDR2, `UNLOCK_DATA2},
              {`UNLOCK_ADDR1, `ERASE_CODE1}, {`UNLOCK_ADDR1, `UNLOCK_DATA1},
              {`UNLOCK_ADDR2, `UNLOCK_DATA2}, {20'h00020, `ERASE_CODE2}};
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      rd_chk(`REG_IRQ_STAT, 32'h0);
      rd_chk(`REG_IRQ_MASK, 32'h0);
      rd_chk(12'h01C, 32'h0);
      apb(1'b0, `REG_STATUS, '0);
      check(rdat & 32'h0000_0006, 32'h0000_0004);
      apb(1'b1, `REG_CTRL, 32'h0);
      rd_chk(`REG_IRQ_STAT, 32'h0);
      $display("test registers done");
      run_cmd(`CMD_READ, 20'h00012, 16'h0, 1'b0);
      rd_chk(`REG_RDATA, 32'h0000_FFFF);
      apb(1'b1, `REG_IRQ_MASK, 32'h0000_0001);
      run_cmd(32'(`CMD_PROGRAM) | 32'h200, 20'h00012, 16'hA5C3, 1'b1);
      check({16'h0, flash_u.mem[8'h12]}, 32'h0000_A5C3);
      run_cmd(`CMD_READ, 20'h00012, 16'h0, 1'b1);
      rd_chk(`REG_RDATA, 32'h0000_A5C3);
      $display("test program done");
      for (int k = 0; k < 10; k++) begin
         run_cmd(`CMD_WRITE, seq[k][35:16], seq[k][15:0], 1'b1);
         if (k == 3 || k == 9) begin
            check({31'h0, ready_busy_n}, 32'h0);
            apb(1'b0, `REG_STATUS, '0);
            check(rdat & 32'h0000_000A, 32'h0);
            tg = flash_u.n_tog;
            run_cmd(32'(`CMD_POLL) | (k == 9 ? 32'h100 : 32'h0), 20'h7FFFF, 16'h0, 1'b1);
            check(32'(flash_u.n_tog - tg >= 2), 32'h1);
            check({31'h0, ready_busy_n}, 32'h1);
         end
         if (k == 3) check({16'h0, flash_u.mem[8'h23]}, 32'h0000_1234);
      end
      check({16'h0, flash_u.mem[8'h23]}, 32'h0000_FFFF);
      check({16'h0, flash_u.mem[8'h12]}, 32'h0000_A5C3);
      run_cmd(`CMD_ERASE, 20'h00010, 16'h0, 1'b1);
      check({16'h0, flash_u.mem[8'h12]}, 32'h0000_FFFF);
      $display("test poll and erase done");
      for (int k = 0; k < 3; k++) run_cmd(`CMD_WRITE, seq[k][35:16], seq[k][15:0], 1'b1);
      run_cmd(`CMD_WRITE, 20'h00030, 16'h0000, 1'b1);
      run_cmd(`CMD_RESET, 20'h0, 16'h0, 1'b1);
      check({31'h0, ready_busy_n}, 32'h1);
      run_cmd(`CMD_RESET, 20'h0, 16'h0, 1'b1);
      run_cmd(`CMD_READ, 20'h00012, 16'h0, 1'b1);
      rd_chk(`REG_RDATA, 32'h0000_FFFF);
      check(32'(flash_u.host_err), 32'h0);
      $display("test reset done");
      print_verdict();
   end

   initial begin
      #(`CLK_PERIOD_NS * 80000);
      err_count++;
      print_verdict();
   end
endmodule : testbench
